/* File: dv/wsm_ctrl_test.sv */
// self-checking bench for the wide-area mode control block
`timescale 1ns/1ps
`default_nettype none
module wsm_ctrl_test
    import wsm_pkg::*;
;
    localparam int FL = 16;
    typedef struct {int cyc; int kind; logic [31:0] val; logic [31:0] mask;} wsm_note_s;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] pcs_tx_data = 8'h00;
    logic echo = 1'b1;
    logic flip = 1'b0;
    logic send_page = 1'b0;
    logic [7:0] inject = 8'h00;
    logic [1:0] page_ab = 2'h0;
    logic [1:0] det = 2'h0;
    logic [1:0] rate_pins = MODE_PINS_ALT;
    logic [31:0] prdata;
    logic pready, pslverr, pcs_tx_ready, pcs_rx_valid, pcs_tx_reset, pcs_rx_reset;
    logic [7:0] pcs_rx_data, serial_tx_output_data, pma_clock_outputs_sel, pma_rx_data;
    logic rate_10g, wan_line, mon_act, dfe_zero, adapt, page_valid, det_10g, det_1g;
    logic [1:0] ability;
    logic [7:0] mctl[6] = '{8'h04, 8'h00, 8'h10, 8'h14, 8'h34, 8'h05};
    logic [4:0] mexp[6] = '{5'h11, 5'h01, 5'h01, 5'h15, 5'h16, 5'h19};
    logic [4:0] neg[5] = '{5'h1C, 5'h14, 5'h03, 5'h01, 5'h02};
    logic [4:0] nexp = 5'b10101;
    string kname[5] = '{"rx data", "tx line", "clock sel", "mode outputs", "apb read"};
    wsm_note_s dq[$];
    wsm_note_s aq[$];
    int cyc = 0;
    int miscompares = 0;
    int tests_run = 0;
    int i;
    int k;
    logic [7:0] b;
    wsm_note_s wn;

    always #50 clock = ~clock;

    wsm_ctrl #(.FRAME_LEN(FL)) i_wsm_ctrl (
        .clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rate_sel_pins(rate_pins), .sig_det_10g(det_10g), .sig_det_1g(det_1g),
        .partner_page_valid(page_valid), .partner_ability(ability),
        .pcs_tx_data(pcs_tx_data), .pcs_tx_ready(pcs_tx_ready), .pcs_rx_data(pcs_rx_data),
        .pcs_rx_valid(pcs_rx_valid), .pcs_tx_reset(pcs_tx_reset), .pcs_rx_reset(pcs_rx_reset),
        .pma_rx_data(pma_rx_data), .serial_tx_output_data(serial_tx_output_data),
        .clock_recovery_unit_rate_10g(rate_10g), .line_rate_wan(wan_line),
        .pma_clock_outputs_sel(pma_clock_outputs_sel), .monitor_active(mon_act),
        .decision_feedback_equalizer_zero(dfe_zero), .adapt_enable(adapt));

    wsm_partner i_wsm_partner (
        .clock(clock), .tx_line(serial_tx_output_data), .rx_line(pma_rx_data), .echo(echo),
        .flip(flip), .inject(inject), .send_page(send_page), .page_ab(page_ab), .det(det),
        .page_valid(page_valid), .ability(ability), .det_10g(det_10g), .det_1g(det_1g));

    function automatic logic [31:0] sample(input int kd);
        case (kd)
            0: sample = {23'h0, pcs_rx_valid, pcs_rx_data};
            1: sample = {24'h0, serial_tx_output_data};
            2: sample = {24'h0, pma_clock_outputs_sel};
            3: sample = {27'h0, rate_10g, wan_line, mon_act, dfe_zero, adapt};
            default: sample = {pslverr, prdata[30:0]};
        endcase
    endfunction

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic fail_wait();
        miscompares++;
        report_and_stop();
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(inout int n, input int lim);
        @(posedge clock);
        n++;
        if (n > lim)
            fail_wait();
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n = 0;
        @(posedge clock);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clock);
        penable <= 1'b1;
        do
            tick(n, 20);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        aq.push_back('{0, 4, e, m});
        apb(a, 1'b0, 32'h0);
    endtask

    // result watcher: oldest note against the outputs
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (psel && penable && pready === 1'b1 && !pwrite && aq.size() > 0)
        begin
            wn = aq.pop_front();
            check(kname[4], wn.val, sample(4) & wn.mask);
        end
        while (dq.size() > 0 && dq[0].cyc <= cyc)
        begin
            wn = dq.pop_front();
            check(kname[wn.kind], wn.val, sample(wn.kind) & wn.mask);
        end
    end

    initial
    begin
        void'($urandom(32'hC4CF));
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        rd(REG_CTRL, CTRL_RESET, 32'h8000FFFF);
        rd(REG_PCS_RST, 32'h0, 32'hFFFFFFFF);
        rd(12'h010, 32'h80000000, 32'hFFFFFFFF);
        rd(REG_STATUS, 32'h4, 32'h80000005);
        $display("test reset values done");
        for (i = 0; i < 6; i++)
        begin
            b = 8'($urandom);
            apb(REG_CTRL, 1'b1, {16'h0, b, mctl[i]});
            dq.push_back('{cyc + 1, 2, {24'h0, b}, '1});
            dq.push_back('{cyc + 3, 3, {27'h0, mexp[i]}, '1});
            repeat (4) @(posedge clock);
        end
        $display("test mode table done");
        apb(REG_CTRL, 1'b1, 32'h4);
        for (i = 0; i < 24; i++)
        begin
            @(posedge clock);
            b = 8'($urandom);
            pcs_tx_data <= b;
            dq.push_back('{cyc + 4, 0, {23'h0, 1'b1, b}, '1});
            check("tx ready", 32'h1, {31'h0, pcs_tx_ready});
        end
        $display("test bypass done");
        apb(REG_CTRL, 1'b1, 32'hC);
        echo <= 1'b0;
        for (i = 0; i < 16; i++)
        begin
            @(posedge clock);
            b = 8'($urandom);
            inject <= b;
            dq.push_back('{cyc + 3, 1, {24'h0, b}, '1});
            dq.push_back('{cyc + 3, 0, {23'h0, 1'b1, b}, '1});
        end
        $display("test loopback done");
        apb(REG_CTRL, 1'b1, 32'h2);
        for (i = 0; i < 5; i++)
        begin
            det <= 2'h0;
            repeat (8) @(posedge clock);
            {send_page, page_ab, det} <= neg[i];
            @(posedge clock);
            send_page <= 1'b0;
            k = 0;
            while (rate_10g !== nexp[i])
                tick(k, 30);
            check("rate select", {31'h0, nexp[i]}, {31'h0, rate_10g});
        end
        $display("test negotiation done");
        det <= 2'h0;
        echo <= 1'b1;
        apb(REG_CTRL, 1'b1, 32'h5);
        apb(REG_PCS_RST, 1'b1, 32'h6);
        k = 0;
        while (pcs_tx_reset !== 1'b1)
            tick(k, 20);
        check("pcs resets", 32'h3, {30'h0, pcs_tx_reset, pcs_rx_reset});
        @(posedge clock);
        check("pcs resets", 32'h0, {30'h0, pcs_tx_reset, pcs_rx_reset});
        k = 0;
        b = 8'h00;
        while (b !== FRAME_A1 || serial_tx_output_data !== FRAME_A2)
        begin
            b = serial_tx_output_data;
            tick(k, 3 * FL);
        end
        k = 0;
        repeat (FL)
        begin
            @(posedge clock);
            k += int'(pcs_tx_ready === 1'b0);
        end
        check("held bytes", 32'h4, k);
        check("frame a2", {24'h0, FRAME_A2}, {24'h0, serial_tx_output_data});
        rd(REG_B1_ERR, 32'h0, 32'h8000FFFF);
        rd(REG_STATUS, 32'hF, 32'h8000FF1F);
        k = 0;
        b = 8'h00;
        while (b !== FRAME_A1 || serial_tx_output_data !== FRAME_A2)
        begin
            b = serial_tx_output_data;
            tick(k, 3 * FL);
        end
        repeat (8) @(posedge clock);
        flip <= 1'b1;
        @(posedge clock);
        flip <= 1'b0;
        repeat (3 * FL) @(posedge clock);
        rd(REG_B1_ERR, 32'h1, 32'h8000FFFF);
        $display("test framing done");
        rst_n <= 1'b0;
        rate_pins <= 2'h0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        rd(REG_CTRL, CTRL_RESET, 32'h8000FFFF);
        rd(REG_STATUS, 32'h0, 32'h80000005);
        $display("test second reset done");
        repeat (6) @(posedge clock);
        report_and_stop();
    end
endmodule
`default_nettype wire

/* File: dv/wsm_partner.sv */
// link partner model: line echo, base pages and signal detects
`timescale 1ns/1ps
`default_nettype none
module wsm_partner
(
    // clock
    input wire logic clock,
    // line
    input wire logic [7:0] tx_line,
    output var logic [7:0] rx_line = 8'h00,
    // bench commands
    input wire logic echo,
    input wire logic flip,
    input wire logic [7:0] inject,
    input wire logic send_page,
    input wire logic [1:0] page_ab,
    input wire logic [1:0] det,
    // negotiation
    output var logic page_valid = 1'b0,
    output var logic [1:0] ability = 2'h0,
    output var logic det_10g = 1'b0,
    output var logic det_1g = 1'b0
);
    always @(posedge clock)
    begin
        rx_line <= echo ? (tx_line ^ {7'h00, flip}) : inject;
        page_valid <= send_page;
        ability <= send_page ? page_ab : ~ability;
        {det_10g, det_1g} <= det;
    end
endmodule
`default_nettype wire

/* File: logic/wsm_ctrl.sv */
// wide-area sublayer, rate selection and pma control for one lane
`timescale 1ns/1ps
`default_nettype none
module wsm_ctrl
    import wsm_pkg::*;
#(
    parameter int FRAME_LEN = 32
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic [1:0] rate_sel_pins,
    input wire logic sig_det_10g,
    input wire logic sig_det_1g,
    // partner base page
    input wire logic partner_page_valid,
    input wire logic [1:0] partner_ability,
    // pcs side
    input wire logic [7:0] pcs_tx_data,
    output logic pcs_tx_ready,
    output logic [7:0] pcs_rx_data,
    output logic pcs_rx_valid,
    output logic pcs_tx_reset,
    output logic pcs_rx_reset,
    // pma side
    input wire logic [7:0] pma_rx_data,
    output logic [7:0] serial_tx_output_data,
    output logic clock_recovery_unit_rate_10g,
    output logic line_rate_wan,
    output logic [7:0] pma_clock_outputs_sel,
    output logic monitor_active,
    output logic decision_feedback_equalizer_zero,
    output logic adapt_enable
);

    if (FRAME_LEN < 8 || FRAME_LEN > 256)
    begin : g_len_check
        $error("FRAME_LEN must lie in 8..256");
    end

    localparam logic [7:0] LAST_IDX = 8'(FRAME_LEN - 1);

    // sonet frame-synchronous scrambler x^7+x^6+1, msb first
    function automatic logic [14:0] scr_byte(input logic [6:0] st, input logic [7:0] d);
        logic [6:0] sr;
        logic [7:0] o;
        sr = st;
        o = d;
        for (int i = 7; i >= 0; i--)
        begin
            o[i] = d[i] ^ sr[6];
            sr = {sr[5:0], sr[6] ^ sr[5]};
        end
        return {sr, o};
    endfunction

    function automatic logic [7:0] next_idx(input logic [7:0] i);
        return (i == LAST_IDX) ? 8'h00 : 8'(i + 8'h01);
    endfunction

    wsm_state_s s;
    wsm_state_s next_s;

    always_comb
    begin
        logic [14:0] sc;
        logic [7:0] tb;
        logic [7:0] rd;
        logic setup;
        logic acc;
        logic [1:0] common;
        sc = 15'h0000;
        tb = 8'h00;
        rd = 8'h00;
        common = LOCAL_ABILITY & partner_ability;
        next_s = s;
        setup = psel && penable && !s.pready;
        acc = psel && penable && s.pready;

        // apb: one wait state, data loaded with pready
        next_s.pready = setup;
        next_s.pslverr = 1'b0;
        if (setup)
        begin
            if (paddr == REG_CTRL)
                next_s.prdata = {16'h0000, s.clk_sel, 2'h0, s.mon_unity, s.mon_en,
                                 s.loopback, s.force_10g, s.an_en, s.wan_en};
            else if (paddr == REG_PCS_RST)
                next_s.prdata = 32'h0000_0000;
            else if (paddr == REG_STATUS)
            begin
                next_s.prdata = 32'h0000_0000;
                next_s.prdata[ST_WAN] = s.wan_en;
                next_s.prdata[ST_RATE_10G] = s.rate_10g;
                next_s.prdata[ST_REF_125] = s.ref125;
                next_s.prdata[ST_IN_FRAME] = (s.rx_st == RX_SYNC);
                next_s.prdata[ST_MON_ACTIVE] = s.mon_active;
                next_s.prdata[ST_AN_DONE] = (s.an_st == AN_GOOD);
                next_s.prdata[ST_PTR_LSB +: 8] = s.rx_ptr;
            end
            else if (paddr == REG_B1_ERR)
                next_s.prdata = {16'h0000, s.b1_err};
            else
            begin
                next_s.prdata = 32'h0000_0000;
                next_s.pslverr = 1'b1;
            end
        end
        next_s.tx_rst = 1'b0;
        next_s.rx_rst = 1'b0;
        if (acc && pwrite)
        begin
            if (paddr == REG_CTRL)
            begin
                next_s.wan_en = pwdata[CTRL_WAN_EN];
                next_s.an_en = pwdata[CTRL_AN_EN];
                next_s.force_10g = pwdata[CTRL_FORCE_10G];
                next_s.loopback = pwdata[CTRL_LOOPBACK];
                next_s.mon_en = pwdata[CTRL_MON_EN];
                next_s.mon_unity = pwdata[CTRL_MON_UNITY];
                next_s.clk_sel = pwdata[CTRL_CLK_SEL_LSB +: 8];
            end
            else if (paddr == REG_PCS_RST)
            begin
                next_s.tx_rst = pwdata[PCS_RST_TX_BIT];
                next_s.rx_rst = pwdata[PCS_RST_RX_BIT];
            end
        end

        // pin synchronisers and rate strap capture after reset
        next_s.mode_s1 = rate_sel_pins;
        next_s.mode_s2 = s.mode_s1;
        next_s.sd_s1 = {sig_det_10g, sig_det_1g};
        next_s.sd_s2 = s.sd_s1;
        if (s.strap_cnt != 2'h3)
            next_s.strap_cnt = 2'(s.strap_cnt + 2'h1);
        if (s.strap_cnt == STRAP_SETTLE)
            next_s.ref125 = (s.mode_s2 == MODE_PINS_ALT);

        // rate negotiation and detection
        if (!s.an_en)
        begin
            next_s.an_st = AN_GOOD;
            next_s.rate_10g = s.force_10g;
        end
        else
        begin
            case (s.an_st)
                AN_LISTEN:
                begin
                    if (partner_page_valid && common != 2'h0)
                    begin
                        next_s.rate_10g = common[1];
                        next_s.an_st = AN_GOOD;
                    end
                    else if (s.sd_s2 != 2'h0)
                    begin
                        next_s.rate_10g = s.sd_s2[1];
                        next_s.an_st = AN_GOOD;
                    end
                end
                AN_GOOD:
                begin
                    if (s.sd_s2 == 2'h0 && !partner_page_valid)
                        next_s.an_st = AN_LISTEN;
                end
                default: next_s.an_st = AN_LISTEN;
            endcase
        end

        // signal monitor hooks
        next_s.mon_active = s.mon_en && next_s.rate_10g;
        next_s.dfe_zero = next_s.mon_active && s.mon_unity;
        next_s.adapt_en = !next_s.dfe_zero;

        // transmit path
        if (!s.wan_en)
        begin
            next_s.tx_cnt = 8'h00;
            tb = pcs_tx_data;
        end
        else
        begin
            next_s.tx_cnt = next_idx(s.tx_cnt);
            if (s.tx_cnt == 8'h00)
                tb = FRAME_A1;
            else if (s.tx_cnt == IDX_A2)
            begin
                tb = FRAME_A2;
                next_s.tx_scr = SCR_SEED;
            end
            else
            begin
                if (s.tx_cnt == IDX_B1)
                    sc = scr_byte(s.tx_scr, s.tx_bref);
                else if (s.tx_cnt == IDX_PTR)
                    sc = scr_byte(s.tx_scr, TX_PTR_VALUE);
                else
                    sc = scr_byte(s.tx_scr, pcs_tx_data);
                tb = sc[7:0];
                next_s.tx_scr = sc[14:8];
            end
            if (s.tx_cnt == 8'h00)
            begin
                next_s.tx_bref = s.tx_bip;
                next_s.tx_bip = tb;
            end
            else
                next_s.tx_bip = s.tx_bip ^ tb;
        end
        next_s.tx_line = s.loopback ? pma_rx_data : tb;
        next_s.tx_ready = !next_s.wan_en || (next_s.tx_cnt >= OH_LEN);

        // receive path
        next_s.rx_prev = pma_rx_data;
        next_s.rx_valid = 1'b0;
        if (!s.wan_en)
        begin
            next_s.rx_st = RX_SEARCH;
            next_s.rx_data = pma_rx_data;
            next_s.rx_valid = 1'b1;
        end
        else
        begin
            case (s.rx_st)
                RX_SEARCH:
                begin
                    next_s.rx_bref_ok = 1'b0;
                    next_s.rx_bip = s.rx_prev ^ pma_rx_data;
                    if (s.rx_prev == FRAME_A1 && pma_rx_data == FRAME_A2)
                    begin
                        next_s.rx_st = RX_SYNC;
                        next_s.rx_cnt = IDX_B1;
                        next_s.rx_scr = SCR_SEED;
                    end
                end
                RX_SYNC:
                begin
                    next_s.rx_cnt = next_idx(s.rx_cnt);
                    if (s.rx_cnt == 8'h00)
                    begin
                        next_s.rx_bref = s.rx_bip;
                        next_s.rx_bref_ok = 1'b1;
                        next_s.rx_bip = pma_rx_data;
                    end
                    else
                        next_s.rx_bip = s.rx_bip ^ pma_rx_data;
                    if (s.rx_cnt == IDX_A2)
                    begin
                        next_s.rx_scr = SCR_SEED;
                        if (!(s.rx_prev == FRAME_A1 && pma_rx_data == FRAME_A2))
                            next_s.rx_st = RX_SEARCH;
                    end
                    else if (s.rx_cnt != 8'h00)
                    begin
                        sc = scr_byte(s.rx_scr, pma_rx_data);
                        rd = sc[7:0];
                        next_s.rx_scr = sc[14:8];
                        if (s.rx_cnt == IDX_B1 && s.rx_bref_ok && rd != s.rx_bref
                            && s.b1_err != 16'hFFFF)
                            next_s.b1_err = 16'(s.b1_err + 16'h0001);
                        if (s.rx_cnt == IDX_PTR)
                            next_s.rx_ptr = rd;
                        if (s.rx_cnt >= OH_LEN)
                        begin
                            next_s.rx_data = rd;
                            next_s.rx_valid = 1'b1;
                        end
                    end
                end
                default: next_s.rx_st = RX_SEARCH;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.an_en <= CTRL_RESET[CTRL_AN_EN];
            s.an_st <= AN_LISTEN;
            s.rx_st <= RX_SEARCH;
            s.adapt_en <= 1'b1;
            s.tx_ready <= 1'b1;
            s.tx_scr <= SCR_SEED;
            s.rx_scr <= SCR_SEED;
        end
        else
            s <= next_s;
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign pcs_tx_ready = s.tx_ready;
    assign pcs_rx_data = s.rx_data;
    assign pcs_rx_valid = s.rx_valid;
    assign pcs_tx_reset = s.tx_rst;
    assign pcs_rx_reset = s.rx_rst;
    assign serial_tx_output_data = s.tx_line;
    assign clock_recovery_unit_rate_10g = s.rate_10g;
    assign line_rate_wan = s.wan_en;
    assign pma_clock_outputs_sel = s.clk_sel;
    assign monitor_active = s.mon_active;
    assign decision_feedback_equalizer_zero = s.dfe_zero;
    assign adapt_enable = s.adapt_en;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    pcs_rst_pulse_a: assert property (psel && penable && pready && pwrite && paddr == REG_PCS_RST
        && pwdata[PCS_RST_TX_BIT] |=> pcs_tx_reset ##1 !pcs_tx_reset)
        else $error("pcs reset pulse wrong");
    wan_ctrl_a: assert property (psel && penable && pready && pwrite && paddr == REG_CTRL
        |=> line_rate_wan == $past(pwdata[CTRL_WAN_EN]))
        else $error("wide-area enable not applied");
    ser_src_a: assert property (rst_n && !s.loopback && !s.wan_en
        |=> serial_tx_output_data == $past(pcs_tx_data))
        else $error("serializer source wrong");
    loopback_a: assert property (s.loopback |=> serial_tx_output_data == $past(pma_rx_data))
        else $error("loopback data wrong");
    bypass_a: assert property (rst_n && !s.wan_en |=> pcs_rx_valid && pcs_rx_data == $past(pma_rx_data))
        else $error("bypass data wrong");
    monitor_gate_a: assert property (monitor_active |-> clock_recovery_unit_rate_10g)
        else $error("monitor active outside 10g");
    unity_gain_a: assert property (decision_feedback_equalizer_zero |-> !adapt_enable)
        else $error("adaptation left on");
    an_priority_a: assert property (s.an_en && s.an_st == AN_LISTEN && partner_page_valid
        && partner_ability == 2'h3 |=> clock_recovery_unit_rate_10g)
        else $error("priority resolution wrong");
    forced_mode_a: assert property (!s.an_en ##1 !s.an_en
        |-> clock_recovery_unit_rate_10g == $past(s.force_10g))
        else $error("forced mode not applied");
    frame_a1_a: assert property (s.wan_en && !s.loopback && s.tx_cnt == 8'h00
        |=> serial_tx_output_data == FRAME_A1 ##1 serial_tx_output_data == FRAME_A2)
        else $error("framing bytes missing");
    rx_lock_a: assert property (s.wan_en && s.wan_en == $past(s.wan_en)
        && s.rx_st == RX_SEARCH && s.rx_prev == FRAME_A1 && pma_rx_data == FRAME_A2
        |=> s.rx_st == RX_SYNC ##[1:300] pcs_rx_valid)
        else $error("frame not found");

    wan_sync_c: cover property (s.wan_en && s.rx_st == RX_SYNC && pcs_rx_valid);
    an_done_c: cover property (s.an_en && s.an_st == AN_LISTEN ##1 s.an_st == AN_GOOD);
    loop_c: cover property (s.loopback && s.wan_en);
    pcs_rst_c: cover property (pcs_tx_reset && pcs_rx_reset);
endmodule
`default_nettype wire

/* File: logic/wsm_pkg.sv */
// constants, types and register map of the wide-area sublayer mode control
package wsm_pkg;
    // register byte addresses
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_PCS_RST = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam logic [11:0] REG_B1_ERR = 12'h00C;
    // control field positions
    localparam int CTRL_WAN_EN = 0;
    localparam int CTRL_AN_EN = 1;
    localparam int CTRL_FORCE_10G = 2;
    localparam int CTRL_LOOPBACK = 3;
    localparam int CTRL_MON_EN = 4;
    localparam int CTRL_MON_UNITY = 5;
    localparam int CTRL_CLK_SEL_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
    // pcs reset field positions
    localparam int PCS_RST_RX_BIT = 1;
    localparam int PCS_RST_TX_BIT = 2;
    // status field positions
    localparam int ST_WAN = 0;
    localparam int ST_RATE_10G = 1;
    localparam int ST_REF_125 = 2;
    localparam int ST_IN_FRAME = 3;
    localparam int ST_MON_ACTIVE = 4;
    localparam int ST_AN_DONE = 5;
    localparam int ST_PTR_LSB = 8;
    // frame layout
    localparam logic [7:0] FRAME_A1 = 8'hF6;
    localparam logic [7:0] FRAME_A2 = 8'h28;
    localparam logic [6:0] SCR_SEED = 7'h7F;
    localparam logic [7:0] IDX_A2 = 8'h01;
    localparam logic [7:0] IDX_B1 = 8'h02;
    localparam logic [7:0] IDX_PTR = 8'h03;
    localparam logic [7:0] OH_LEN = 8'h04;
    localparam logic [7:0] TX_PTR_VALUE = 8'h00;
    // reference clock strap
    localparam int REFCLK_DEFAULT_KHZ = 156250;
    localparam int REFCLK_ALT_KHZ = 125000;
    localparam logic [1:0] MODE_PINS_ALT = 2'h2;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    // ability bits: bit1 10g, bit0 1g
    localparam logic [1:0] LOCAL_ABILITY = 2'h3;

    typedef enum logic [0:0] {AN_LISTEN, AN_GOOD} wsm_an_e;
    typedef enum logic [0:0] {RX_SEARCH, RX_SYNC} wsm_rx_e;

    typedef struct packed {
        logic wan_en;
        logic an_en;
        logic force_10g;
        logic loopback;
        logic mon_en;
        logic mon_unity;
        logic [7:0] clk_sel;
        logic tx_rst;
        logic rx_rst;
        logic [1:0] mode_s1;
        logic [1:0] mode_s2;
        logic [1:0] sd_s1;
        logic [1:0] sd_s2;
        logic [1:0] strap_cnt;
        logic ref125;
        wsm_an_e an_st;
        logic rate_10g;
        logic mon_active;
        logic dfe_zero;
        logic adapt_en;
        logic [7:0] tx_cnt;
        logic [6:0] tx_scr;
        logic [7:0] tx_bip;
        logic [7:0] tx_bref;
        logic [7:0] tx_line;
        logic tx_ready;
        wsm_rx_e rx_st;
        logic [7:0] rx_cnt;
        logic [6:0] rx_scr;
        logic [7:0] rx_prev;
        logic [7:0] rx_bip;
        logic [7:0] rx_bref;
        logic rx_bref_ok;
        logic [15:0] b1_err;
        logic [7:0] rx_ptr;
        logic [7:0] rx_data;
        logic rx_valid;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } wsm_state_s;
endpackage
